// file: testbench.sv
// Self-checking testbench for the vectored interrupt request latch
`timescale 1ns/1ps
module testbench
    import virl_pkg::*;
;
    typedef logic [15:0] virl_vq_t[$];
    logic        clock, nrst, hsel, hwrite, vecAck, cpuIrq, irqOut;
    logic        hreadyout, hresp, lowVoltDet, compOut;
    logic        serialRxEvt, serialTxEvt, converterEvt, timer1Evt, timer0Evt;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  portaPins;
    logic [3:0]  portcPins, ackDelay;
    logic [4:0]  trapEvt;
    logic [15:0] cpuVector;
    int          miscompares, n_compared, nv;

    virl_top virl_top_i (.clock(clock), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .portaPins(portaPins),
        .portcPins(portcPins), .lowVoltDet(lowVoltDet), .compOut(compOut),
        .serialRxEvt(serialRxEvt), .serialTxEvt(serialTxEvt),
        .converterEvt(converterEvt), .timer1Evt(timer1Evt),
        .timer0Evt(timer0Evt),
        .trapEvt(trapEvt), .vecAck(vecAck), .cpuIrq(cpuIrq),
        .cpuVector(cpuVector), .irqOut(irqOut));
    virl_core_model core_i (.clock(clock), .nrst(nrst), .cpuIrq(cpuIrq),
        .cpuVector(cpuVector), .ackDelay(ackDelay), .vecAck(vecAck));

    // Free-running clock at 125 MHz
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic end_sim();
        $display("Counts: %0d compared, %0d mismatched", n_compared,
                 miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t %s: got %h exp %h", $time, msg, got, exp);
        end
    endtask

    // One AHB-Lite single transfer; entered just after a rising edge
    task automatic bus(input logic [11:0] a, input logic w,
                       input logic [31:0] wd, output logic [31:0] rdv);
        hsel   <= 1'b1;
        haddr  <= {20'h00000, a};
        htrans <= HTRANS_NSEQ;
        hwrite <= w;
        hsize  <= HSIZE_WORD;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(a, 1'b1, d, rd);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
                         input string msg);
        bus(a, 1'b0, 32'h00000000, rd);
        chk(rd, e, msg);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Waits a bounded time for the core to take the listed vectors in order
    task automatic exp_vecs(input virl_vq_t e);
        int k;
        k = 0;
        while (core_i.got.size() < nv + e.size() && k < 400) begin
            @(posedge clock);
            k++;
        end
        chk(core_i.got.size(), nv + e.size(), "vector count");
        foreach (e[i]) begin
            if (nv + i < core_i.got.size()) begin
                chk({16'h0000, core_i.got[nv + i]}, {16'h0000, e[i]}, "vec");
            end
        end
        nv = core_i.got.size();
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        #200000;
        miscompares++;
        $display("MISMATCH %0t watchdog expired", $time);
        end_sim();
    end

    initial begin
        {hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
        {portaPins, portcPins, lowVoltDet, compOut, trapEvt} = '0;
        {serialRxEvt, serialTxEvt, converterEvt, timer1Evt, timer0Evt} = '0;
        {miscompares, n_compared, nv} = '0;
        ackDelay = 4'h0;
        nrst = 1'b0;
        cyc(20);
        nrst <= 1'b1;
        @(posedge clock);
        rdchk(PIN_REQ_ADDR, 32'h0, "pin req reset");
        rdchk(PER_REQ_ADDR, 32'h0, "per req reset");
        rdchk(12'h200, 32'h0, "unmapped read");
        chk(hresp, 1'b0, "okay response");
        $display("Test reset values done");
        // Polled mode: events latch but never reach the core
        portaPins  <= 8'h20;
        lowVoltDet <= 1'b1;
        compOut    <= 1'b1;
        serialRxEvt <= 1'b1;
        serialTxEvt <= 1'b1;
        converterEvt <= 1'b1;
        @(posedge clock);
        {serialRxEvt, serialTxEvt, converterEvt} <= 3'b000;
        cyc(4);
        lowVoltDet <= 1'b0;
        compOut    <= 1'b0;
        cyc(6);
        rdchk(PIN_REQ_ADDR, 32'he0, "pin req polled");
        rdchk(PER_REQ_ADDR, 32'h19, "per req polled");
        wr(PIN_REQ_ADDR, 32'hff);
        rdchk(PIN_REQ_ADDR, 32'hff, "pin req write");
        wr(PER_ENL_ADDR, 32'h19);
        rdchk(PER_ENL_ADDR, 32'h19, "per enl layout");
        wr(PIN_ENL_ADDR, 32'hff);
        chk(core_i.got.size(), 0, "no vector while disabled");
        $display("Test polled mode done");
        // Vectored mode: all pending, pin 2 on falling edge
        wr(CTRL_ADDR, 32'h00000401);
        exp_vecs('{VEC_RX, VEC_TX, VEC_CONV, 16'h0018, 16'h001a,
                   16'h001c, 16'h001e, 16'h0020, 16'h0022, 16'h0024,
                   16'h0026});
        rdchk(PIN_REQ_ADDR, 32'h0, "pin req cleared");
        rdchk(PER_REQ_ADDR, 32'h0, "per req cleared");
        $display("Test priority order done");
        // Slow core; falling-edge select ignores the rise
        ackDelay <= 4'h5;
        portaPins <= 8'h24;
        cyc(10);
        chk(core_i.got.size(), nv, "rising edge ignored");
        portaPins <= 8'h20;
        exp_vecs('{16'h0022});
        // Port C both edges, pin 3 before pin 0
        wr(PORTC_EN_ADDR, 32'h0f);
        portcPins <= 4'h9;
        exp_vecs('{16'h0030, 16'h0036});
        portcPins <= 4'h8;
        exp_vecs('{16'h0036});
        portcPins <= 4'h0;
        exp_vecs('{16'h0030});
        $display("Test edges done");
        // Traps ignore the global enable; maskable events do not
        wr(CTRL_ADDR, 32'h0);
        ackDelay <= 4'h0;
        trapEvt <= 5'h1f;
        serialRxEvt <= 1'b1;
        {timer1Evt, timer0Evt} <= 2'b11;
        @(posedge clock);
        trapEvt <= 5'h00;
        serialRxEvt <= 1'b0;
        {timer1Evt, timer0Evt} <= 2'b00;
        exp_vecs('{VEC_RESET, VEC_WDT, VEC_OSCF, VEC_WOSCF,
                   VEC_ILLEGAL});
        cyc(20);
        chk(core_i.got.size(), nv, "rx held while disabled");
        rdchk(PER_REQ_ADDR, 32'h10, "rx pending");
        rdchk(VEC_ADDR, {16'h0000, VEC_ILLEGAL}, "vector reg");
        wr(CTRL_ADDR, 32'h1);
        exp_vecs('{VEC_TIMER1, VEC_TIMER0, VEC_RX});
        $display("Test traps done");
        // Status, mask and level interrupt
        rdchk(IRQ_STAT_ADDR, 32'h7, "status bits");
        chk(irqOut, 1'b0, "irq masked");
        wr(IRQ_MASK_ADDR, 32'h2);
        cyc(2);
        chk(irqOut, 1'b1, "irq unmasked");
        wr(IRQ_STAT_ADDR, 32'h2);
        cyc(2);
        chk(irqOut, 1'b0, "irq cleared");
        rdchk(IRQ_STAT_ADDR, 32'h5, "status after clear");
        $display("Test interrupt status done");
        end_sim();
    end
endmodule

// file: virl_core_model.sv
// Processor-core model that takes vectored requests and acknowledges them
`timescale 1ns/1ps
module virl_core_model
    import virl_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        cpuIrq,
    input  wire logic [15:0] cpuVector,
    input  wire logic [3:0]  ackDelay,
    output logic             vecAck
);
    logic [3:0]  waitCnt;
    logic [15:0] got[$];
    // Ack after ackDelay cycles as a one-cycle pulse; the cycle after an ack
    // is skipped so a request still standing from before is not taken twice
    always @(posedge clock) begin
        if (!nrst) begin
            vecAck  <= 1'b0;
            waitCnt <= 4'h0;
        end else if (vecAck) begin
            vecAck  <= 1'b0;
            waitCnt <= 4'h0;
        end else if (cpuIrq === 1'b1) begin
            if (waitCnt >= ackDelay) begin
                vecAck <= 1'b1;
                got.push_back(cpuVector);
            end else begin
                waitCnt <= waitCnt + 4'h1;
            end
        end
    end
endmodule

// file: virl_pkg.sv
// Package: register map, vectors and field layout of the request latch
package virl_pkg;
    // Byte addresses on the register bus
    localparam logic [11:0] PIN_REQ_ADDR   = 12'hfc3;
    localparam logic [11:0] PER_REQ_ADDR   = 12'h100;
    localparam logic [11:0] PER_ENL_ADDR   = 12'h104;
    localparam logic [11:0] PER_ENH_ADDR   = 12'h108;
    localparam logic [11:0] PIN_ENL_ADDR   = 12'h10c;
    localparam logic [11:0] PIN_ENH_ADDR   = 12'h110;
    localparam logic [11:0] PORTC_REQ_ADDR = 12'h114;
    localparam logic [11:0] CTRL_ADDR      = 12'h118;
    localparam logic [11:0] VEC_ADDR       = 12'h11c;
    localparam logic [11:0] IRQ_STAT_ADDR  = 12'h120;
    localparam logic [11:0] IRQ_MASK_ADDR  = 12'h124;
    localparam logic [11:0] PORTC_EN_ADDR  = 12'h128;
    // Reset values
    localparam logic [7:0]  REQ_RESET      = 8'h00;
    localparam logic [7:0]  EN_RESET       = 8'h00;
    // Peripheral request field positions
    localparam int SERIAL_RX_BIT  = 4;
    localparam int SERIAL_TX_BIT  = 3;
    localparam int CONVERTER_BIT  = 0;
    localparam logic [7:0] PER_IMPL_MASK = 8'h19;
    // Control register bits
    localparam int CTRL_GIE_BIT   = 0;
    localparam int CTRL_PAEDGE_LO = 8;
    // Vectors in descending priority
    localparam logic [15:0] VEC_RESET   = 16'h0002;
    localparam logic [15:0] VEC_WDT     = 16'h0004;
    localparam logic [15:0] VEC_OSCF    = 16'h003a;
    localparam logic [15:0] VEC_WOSCF   = 16'h003c;
    localparam logic [15:0] VEC_ILLEGAL = 16'h0006;
    localparam logic [15:0] VEC_TIMER1  = 16'h000a;
    localparam logic [15:0] VEC_TIMER0  = 16'h000c;
    localparam logic [15:0] VEC_RX      = 16'h000e;
    localparam logic [15:0] VEC_TX      = 16'h0010;
    localparam logic [15:0] VEC_CONV    = 16'h0016;
    localparam logic [15:0] VEC_PA_BASE = 16'h0018;
    localparam logic [15:0] VEC_PC_BASE = 16'h0030;
    localparam logic [15:0] VEC_STEP    = 16'h0002;
    // Priority levels from high/low enable pairs
    localparam logic [1:0]  LVL_OFF     = 2'h0;
    // AHB encodings
    localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD  = 3'h2;
endpackage

// file: virl_prio_pick.sv
// Fixed-priority picker over a request vector, index 0 highest
`timescale 1ns/1ps
module virl_prio_pick
    import virl_pkg::*;
#(
    parameter int N = 17
) (
    input  wire logic [N-1:0]         reqIn,
    output logic                      anyReq,
    output logic [$clog2(N)-1:0]      pickIdx
);
    initial begin
        if (N < 2) $error("N must be at least 2");
    end

    // Scan from lowest priority so the lowest set index wins last
    always_comb begin
        pickIdx = '0;
        for (int k = N - 1; k >= 0; k--) begin
            if (reqIn[k]) pickIdx = k[$clog2(N)-1:0];
        end
    end
    assign anyReq = |reqIn;
endmodule

// file: virl_sync_edge.sv
// Two-flop synchroniser with selectable edge detection per bit
`timescale 1ns/1ps
module virl_sync_edge
    import virl_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             clock,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] pinIn,
    input  wire logic [WIDTH-1:0] fallSel,
    input  wire logic             bothEdges,
    output logic      [WIDTH-1:0] edgePulse
);
    initial begin
        if (WIDTH < 1) $error("WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] prev_q;

    // Only sync_q and prev_q feed the edge logic; meta_q is isolated
    always_ff @(posedge clock) begin
        if (!nrst) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= pinIn;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Per-bit edge select: both edges, or rising unless falling chosen
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_edge
            wire rise = sync_q[i] & ~prev_q[i];
            wire fall = ~sync_q[i] & prev_q[i];
            assign edgePulse[i] = bothEdges ? (rise | fall)
                                : (fallSel[i] ? fall : rise);
        end
    endgenerate
endmodule

// file: virl_top.sv
// Vectored interrupt request latch with AHB-Lite register slave
`timescale 1ns/1ps
module virl_top
    import virl_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic [7:0]  portaPins,
    input  wire logic [3:0]  portcPins,
    input  wire logic        lowVoltDet,
    input  wire logic        compOut,
    input  wire logic        serialRxEvt,
    input  wire logic        serialTxEvt,
    input  wire logic        converterEvt,
    input  wire logic        timer1Evt,
    input  wire logic        timer0Evt,
    input  wire logic [4:0]  trapEvt,
    input  wire logic        vecAck,
    output logic             cpuIrq,
    output logic      [15:0] cpuVector,
    output logic             irqOut
);
    localparam int NSRC = 22;

    // Every check below runs on the bus clock and rests while reset is held
    default clocking dc_main @(posedge clock);
    endclocking
    default disable iff (!nrst);

    logic [7:0]  pinReq_q, perReq_q, perEnl_q, perEnh_q, pinEnl_q, pinEnh_q;
    logic [3:0]  pcReq_q, pcEn_q;
    logic [4:0]  trapReq_q;
    logic [1:0]  tmrReq_q;
    logic [15:0] ctrl_q;
    logic [2:0]  stat_q, mask_q;
    logic        aWr_q;
    logic [11:0] aAddr_q;
    logic [31:0] hrdata_q;
    logic        cpuIrq_q, irqOut_q;
    logic [15:0] cpuVector_q;
    logic [4:0]  pickIdx_q;
    logic [1:0]  lvdSync_q, cmpSync_q;

    // Pin edge detection (pins are asynchronous)
    wire  [7:0] paEdge;
    wire  [3:0] pcEdge;
    virl_sync_edge #(.WIDTH(8)) u_pa (
        .clock     (clock),
        .nrst      (nrst),
        .pinIn     (portaPins),
        .fallSel   (ctrl_q[CTRL_PAEDGE_LO +: 8]),
        .bothEdges (1'b0),
        .edgePulse (paEdge)
    );
    virl_sync_edge #(.WIDTH(4)) u_pc (
        .clock     (clock),
        .nrst      (nrst),
        .pinIn     (portcPins),
        .fallSel   (4'h0),
        .bothEdges (1'b1),
        .edgePulse (pcEdge)
    );

    // Detector and comparator share port A vectors 7 and 6
    always_ff @(posedge clock) begin
        if (!nrst) begin
            lvdSync_q <= 2'h0;
            cmpSync_q <= 2'h0;
        end else begin
            lvdSync_q <= {lvdSync_q[0], lowVoltDet};
            cmpSync_q <= {cmpSync_q[0], compOut};
        end
    end
    wire lvdSet = lvdSync_q[1];
    wire cmpSet = cmpSync_q[1];

    // Source set vectors
    wire [7:0] pinSet = paEdge | {lvdSet, cmpSet, 6'h00};
    wire [7:0] perSet = {3'h0, serialRxEvt, serialTxEvt, 2'h0,
                         converterEvt};

    // Bus address phase decode
    wire        addrPh = hsel & hready & (htrans == HTRANS_NSEQ);
    wire        wrPin  = aWr_q & (aAddr_q == PIN_REQ_ADDR);
    wire        wrPer  = aWr_q & (aAddr_q == PER_REQ_ADDR);
    wire        wrPc   = aWr_q & (aAddr_q == PORTC_REQ_ADDR);
    wire        wrStat = aWr_q & (aAddr_q == IRQ_STAT_ADDR);
    wire [7:0]  wb     = hwdata[7:0];

    // Priority levels from enable pairs
    wire [1:0] rxLvl   = {perEnh_q[SERIAL_RX_BIT], perEnl_q[SERIAL_RX_BIT]};
    wire [1:0] txLvl   = {perEnh_q[SERIAL_TX_BIT], perEnl_q[SERIAL_TX_BIT]};
    wire [1:0] cvLvl   = {perEnh_q[CONVERTER_BIT], perEnl_q[CONVERTER_BIT]};
    wire [7:0] pinOn;
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_lvl
            assign pinOn[g] = {pinEnh_q[g], pinEnl_q[g]} != LVL_OFF;
        end
    endgenerate

    // Candidate vector: index 0 is highest priority
    wire gie = ctrl_q[CTRL_GIE_BIT];
    wire [NSRC-1:0] cand = {
        {pcReq_q[0], pcReq_q[1], pcReq_q[2], pcReq_q[3]} &
        {pcEn_q[0], pcEn_q[1], pcEn_q[2], pcEn_q[3]},
        {pinReq_q[0], pinReq_q[1], pinReq_q[2], pinReq_q[3],
         pinReq_q[4], pinReq_q[5], pinReq_q[6], pinReq_q[7]} &
        {pinOn[0], pinOn[1], pinOn[2], pinOn[3],
         pinOn[4], pinOn[5], pinOn[6], pinOn[7]},
        perReq_q[CONVERTER_BIT] & (cvLvl != LVL_OFF),
        perReq_q[SERIAL_TX_BIT] & (txLvl != LVL_OFF),
        perReq_q[SERIAL_RX_BIT] & (rxLvl != LVL_OFF),
        tmrReq_q[0], tmrReq_q[1],
        trapReq_q};

    wire       anyCand;
    wire [4:0] pickIdx;
    virl_prio_pick #(.N(NSRC)) u_pick (
        .reqIn   (cand),
        .anyReq  (anyCand),
        .pickIdx (pickIdx)
    );

    // Vector table lookup by picked index
    logic [15:0] vecOf;
    always_comb begin
        case (pickIdx)
            5'd0:    vecOf = VEC_RESET;
            5'd1:    vecOf = VEC_WDT;
            5'd2:    vecOf = VEC_OSCF;
            5'd3:    vecOf = VEC_WOSCF;
            5'd4:    vecOf = VEC_ILLEGAL;
            5'd5:    vecOf = VEC_TIMER1;
            5'd6:    vecOf = VEC_TIMER0;
            5'd7:    vecOf = VEC_RX;
            5'd8:    vecOf = VEC_TX;
            5'd9:    vecOf = VEC_CONV;
            default: vecOf = (pickIdx < 5'd18)
                ? 16'(VEC_PA_BASE + 16'(pickIdx - 5'd10) * VEC_STEP)
                : 16'(VEC_PC_BASE + 16'(pickIdx - 5'd18) * VEC_STEP);
        endcase
    end

    // Traps are not maskable; maskable ones need global enable
    wire trapPick = anyCand & (pickIdx < 5'd5);
    wire fire     = anyCand & (gie | trapPick) & ~cpuIrq_q;
    wire ackHit   = cpuIrq_q & vecAck;

    // Clear mask of the acknowledged source
    wire [NSRC-1:0] ackClr = ackHit ? (NSRC'(1) << pickIdx_q) : '0;
    wire [7:0] pinAckClr = {ackClr[10], ackClr[11], ackClr[12], ackClr[13],
                            ackClr[14], ackClr[15], ackClr[16], ackClr[17]};
    wire [7:0] perAckClr = {3'h0, ackClr[7], ackClr[8], 2'h0, ackClr[9]};
    // Port C pin 3 sits at the top of its group, so the order is reversed
    wire [3:0] pcAckClr  = {ackClr[18], ackClr[19], ackClr[20], ackClr[21]};

    // Next values: set wins over software and acknowledge clears
    wire [7:0] pinReq_d = ((wrPin ? wb : pinReq_q) & ~pinAckClr) | pinSet;
    wire [7:0] perReq_d = (((wrPer ? wb : perReq_q) & ~perAckClr) | perSet)
                          & PER_IMPL_MASK;
    wire [3:0] pcReq_d  = ((wrPc ? wb[3:0] : pcReq_q) & ~pcAckClr)
                          | pcEdge;
    wire [4:0] trap_d   = (trapReq_q & ~ackClr[4:0]) | trapEvt;
    wire [1:0] tmr_d    = (tmrReq_q & ~{ackClr[5], ackClr[6]})
                          | {timer1Evt, timer0Evt};

    // Sticky status: 0 new vector, 1 pin event, 2 trap
    wire [2:0] statSet  = {|trapEvt, |pinSet, fire};
    wire [2:0] stat_d   = (stat_q & ~(wrStat ? wb[2:0] : 3'h0)) | statSet;

    // Request latches
    always_ff @(posedge clock) begin
        if (!nrst) begin
            pinReq_q  <= REQ_RESET;
            perReq_q  <= REQ_RESET;
            pcReq_q   <= 4'h0;
            trapReq_q <= 5'h00;
            tmrReq_q  <= 2'h0;
            stat_q    <= 3'h0;
        end else begin
            pinReq_q  <= pinReq_d;
            perReq_q  <= perReq_d;
            pcReq_q   <= pcReq_d;
            trapReq_q <= trap_d;
            tmrReq_q  <= tmr_d;
            stat_q    <= stat_d;
        end
    end

    // Software-written configuration
    always_ff @(posedge clock) begin
        if (!nrst) begin
            perEnl_q <= EN_RESET;
            perEnh_q <= EN_RESET;
            pinEnl_q <= EN_RESET;
            pinEnh_q <= EN_RESET;
            pcEn_q   <= 4'h0;
            ctrl_q   <= 16'h0000;
            mask_q   <= 3'h0;
        end else if (aWr_q) begin
            if (aAddr_q == PER_ENL_ADDR)
                perEnl_q <= wb & PER_IMPL_MASK;
            else if (aAddr_q == PER_ENH_ADDR)
                perEnh_q <= wb & PER_IMPL_MASK;
            else if (aAddr_q == PIN_ENL_ADDR)
                pinEnl_q <= wb;
            else if (aAddr_q == PIN_ENH_ADDR)
                pinEnh_q <= wb;
            else if (aAddr_q == PORTC_EN_ADDR)
                pcEn_q <= wb[3:0];
            else if (aAddr_q == CTRL_ADDR)
                ctrl_q <= hwdata[15:0];
            else if (aAddr_q == IRQ_MASK_ADDR)
                mask_q <= wb[2:0];
        end
    end

    // Read mux; unmapped addresses read zero
    wire [11:0] ra = haddr[11:0];
    wire [31:0] rdMux =
        (ra == PIN_REQ_ADDR)   ? {24'h0, pinReq_d} :
        (ra == PER_REQ_ADDR)   ? {24'h0, perReq_d} :
        (ra == PER_ENL_ADDR)   ? {24'h0, perEnl_q} :
        (ra == PER_ENH_ADDR)   ? {24'h0, perEnh_q} :
        (ra == PIN_ENL_ADDR)   ? {24'h0, pinEnl_q} :
        (ra == PIN_ENH_ADDR)   ? {24'h0, pinEnh_q} :
        (ra == PORTC_REQ_ADDR) ? {28'h0, pcReq_d} :
        (ra == PORTC_EN_ADDR)  ? {28'h0, pcEn_q} :
        (ra == CTRL_ADDR)      ? {16'h0, ctrl_q} :
        (ra == VEC_ADDR)       ? {15'h0, cpuIrq_q, cpuVector_q} :
        (ra == IRQ_STAT_ADDR)  ? {29'h0, stat_q} :
        (ra == IRQ_MASK_ADDR)  ? {29'h0, mask_q} : 32'h0;

    // Bus phase tracking; zero wait states
    always_ff @(posedge clock) begin
        if (!nrst) begin
            aWr_q    <= 1'b0;
            aAddr_q  <= 12'h000;
            hrdata_q <= 32'h0;
        end else begin
            aWr_q    <= addrPh & hwrite;
            aAddr_q  <= addrPh ? haddr[11:0] : 12'h000;
            hrdata_q <= (addrPh & ~hwrite) ? rdMux : 32'h0;
        end
    end

    // Core request and vector, held until acknowledged
    always_ff @(posedge clock) begin
        if (!nrst) begin
            cpuIrq_q    <= 1'b0;
            cpuVector_q <= 16'h0000;
            pickIdx_q   <= 5'h00;
            irqOut_q    <= 1'b0;
        end else begin
            if (fire) begin
                cpuIrq_q    <= 1'b1;
                cpuVector_q <= vecOf;
                pickIdx_q   <= pickIdx;
            end else if (ackHit) begin
                cpuIrq_q <= 1'b0;
            end
            irqOut_q <= |(stat_d & mask_q);
        end
    end

    assign hrdata    = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign cpuIrq    = cpuIrq_q;
    assign cpuVector = cpuVector_q;
    assign irqOut    = irqOut_q;

    // Checks; the handshake is split into waiting and taken steps
    sequence s_ackd;
        cpuIrq_q && vecAck;
    endsequence
    sequence s_waiting;
        cpuIrq_q && !vecAck;
    endsequence
    a_ack_clears_irq: assert property (
        s_ackd |=> !cpuIrq_q)
        else $error("request not dropped after acknowledge");
    a_vec_held: assert property (
        s_waiting |=> (cpuIrq_q && $stable(cpuVector_q)))
        else $error("vector changed before acknowledge");
    a_no_gie_no_irq: assert property (
        (!gie && !cpuIrq_q && !trapPick) |=> !cpuIrq_q)
        else $error("core interrupted while globally disabled");
    a_gie_fires: assert property (
        (gie && anyCand && !cpuIrq_q) |=> cpuIrq_q)
        else $error("pending request not forwarded");
    a_pin_set: assert property (
        paEdge[3] |=> pinReq_q[3])
        else $error("pin request not latched");
    a_lvd_pin7: assert property (
        lvdSet |=> pinReq_q[7])
        else $error("low-voltage request not latched");
    a_reset_zero: assert property (
        $rose(nrst) |-> (pinReq_q == 8'h00))
        else $error("pin request register not cleared by reset");
    a_per_resv: assert property (
        (perReq_q[2:1] == 2'h0) && (perEnl_q[2:1] == 2'h0))
        else $error("reserved peripheral bits set");
    a_rx_bit: assert property (
        serialRxEvt |=> perReq_q[4])
        else $error("serial receive request not latched");
    a_tx_bit: assert property (
        serialTxEvt |=> perReq_q[3])
        else $error("serial transmit request not latched");
    a_conv_bit: assert property (
        converterEvt |=> perReq_q[0])
        else $error("converter request not latched");
    a_trap_vec: assert property (
        (fire && pickIdx == 5'd0) |=> cpuVector_q == 16'h0002)
        else $error("reset vector wrong");
    a_trap_first: assert property (
        (fire && trapReq_q[0]) |=> (cpuVector_q == VEC_RESET))
        else $error("reset trap not taken first");
    a_pa7_vec: assert property (
        (fire && pickIdx == 5'd10) |=> cpuVector_q == 16'h0018)
        else $error("port A pin 7 vector wrong");
    a_pa_src_vec: assert property (
        (fire && pickIdx >= 5'd10 && pickIdx < 5'd18 && pinReq_q[7]
         && pinOn[7]) |=> (cpuVector_q == VEC_PA_BASE))
        else $error("port A pin 7 not first among pins");
    a_pc0_vec: assert property (
        (fire && pickIdx == 5'd21) |=> cpuVector_q == 16'h0036)
        else $error("port C pin 0 vector wrong");
    a_pc_src_vec: assert property (
        (fire && pickIdx >= 5'd18 && pcReq_q[3] && pcEn_q[3])
        |=> (cpuVector_q == VEC_PC_BASE))
        else $error("port C pin 3 not first among port C");
endmodule
